// ==== bdps_pkg.sv ====
// Shared constants and types for the boot default and power state block.
package bdps_pkg;

  // Strap selectors, already digitised from the straps by the analog front end.
  localparam int unsigned STRAP_W = 4;

  // Dead-battery modes.
  typedef enum logic [2:0]
  {
    BDPS_DB_NO_RESPONSE,
    BDPS_DB_WAIT_SUPPLY_INT,
    BDPS_DB_HOST_WAIT_INT,
    BDPS_DB_WAIT_SUPPLY_EXT,
    BDPS_DB_HOST_WAIT_EXT,
    BDPS_DB_NO_WAIT
  } bdps_db_t;

  // Default configurations.
  typedef enum logic [2:0]
  {
    BDPS_CFG_SAFE,
    BDPS_CFG_WAIT,
    BDPS_CFG_1,
    BDPS_CFG_2,
    BDPS_CFG_3,
    BDPS_CFG_4,
    BDPS_CFG_5,
    BDPS_CFG_RSVD
  } bdps_cfg_t;

  // Core clock selects.
  localparam logic [1:0] CLK_SEL_12M = 2'h0;
  localparam logic [1:0] CLK_SEL_5M = 2'h1;
  localparam logic [1:0] CLK_SEL_100K = 2'h2;

  // Port roles.
  localparam logic [1:0] ROLE_OFF = 2'h0;
  localparam logic [1:0] ROLE_DFP = 2'h1;
  localparam logic [1:0] ROLE_UFP = 2'h2;
  localparam logic [1:0] ROLE_LEGACY_SINK = 2'h3;

  // Sink voltage ceiling, in volts, and currents in milliamps.
  localparam logic [4:0] SINK_V_5 = 5'h05;
  localparam logic [4:0] SINK_V_20 = 5'h14;
  localparam logic [11:0] SINK_MIN_MA = 12'h384;
  localparam logic [11:0] SINK_MAX_MA = 12'hbb8;
  localparam logic [11:0] SRC_MA = 12'hbb8;

  // Cycles the oscillator and clock need to settle before a wake event is served.
  localparam logic [3:0] WAKE_SETTLE_CYC = 4'h4;

endpackage

// ==== bdps_strap_decode.sv ====
// Strap decoder: maps the strap pair to dead-battery mode and default configuration.
`timescale 1ns/1ps
`default_nettype none
module bdps_strap_decode
(
  input wire logic spi_data_in_strap,
  input wire logic [bdps_pkg::STRAP_W-1:0] analog_strap_input_one,
  output bdps_pkg::bdps_db_t db_mode,
  output bdps_pkg::bdps_cfg_t cfg
);

  // Each analog band is one code step; bands outside the table fall to the safe configuration, and to the no-wait mode with the SPI strap set.
  always_comb
  begin
    db_mode = bdps_pkg::BDPS_DB_NO_RESPONSE;
    cfg = bdps_pkg::BDPS_CFG_SAFE;
    if (spi_data_in_strap)
    begin
      case (analog_strap_input_one)
        4'h2: db_mode = bdps_pkg::BDPS_DB_WAIT_SUPPLY_INT;
        4'h3:
        begin
          db_mode = bdps_pkg::BDPS_DB_HOST_WAIT_INT;
          cfg = bdps_pkg::BDPS_CFG_WAIT;
        end
        4'h4: db_mode = bdps_pkg::BDPS_DB_WAIT_SUPPLY_EXT;
        4'h5:
        begin
          db_mode = bdps_pkg::BDPS_DB_HOST_WAIT_EXT;
          cfg = bdps_pkg::BDPS_CFG_WAIT;
        end
        4'h0, 4'h1: db_mode = bdps_pkg::BDPS_DB_NO_RESPONSE;
        default: db_mode = bdps_pkg::BDPS_DB_NO_WAIT;
      endcase
    end
    else
    begin
      case (analog_strap_input_one)
        4'h1: cfg = bdps_pkg::BDPS_CFG_1;
        4'h2:
        begin
          db_mode = bdps_pkg::BDPS_DB_NO_WAIT;
          cfg = bdps_pkg::BDPS_CFG_2;
        end
        4'h3:
        begin
          db_mode = bdps_pkg::BDPS_DB_HOST_WAIT_INT;
          cfg = bdps_pkg::BDPS_CFG_WAIT;
        end
        4'h4:
        begin
          db_mode = bdps_pkg::BDPS_DB_NO_WAIT;
          cfg = bdps_pkg::BDPS_CFG_3;
        end
        4'h5:
        begin
          db_mode = bdps_pkg::BDPS_DB_HOST_WAIT_EXT;
          cfg = bdps_pkg::BDPS_CFG_WAIT;
        end
        4'h6:
        begin
          db_mode = bdps_pkg::BDPS_DB_NO_WAIT;
          cfg = bdps_pkg::BDPS_CFG_4;
        end
        4'h7:
        begin
          db_mode = bdps_pkg::BDPS_DB_NO_WAIT;
          cfg = bdps_pkg::BDPS_CFG_RSVD;
        end
        4'h8: cfg = bdps_pkg::BDPS_CFG_RSVD;
        4'h9:
        begin
          db_mode = bdps_pkg::BDPS_DB_NO_WAIT;
          cfg = bdps_pkg::BDPS_CFG_5;
        end
        default: cfg = bdps_pkg::BDPS_CFG_SAFE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== bdps_top.sv ====
// Boot default selection and Active, Idle, Sleep power state control.
`timescale 1ns/1ps
`default_nettype none
module bdps_top
(
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_data_in_strap,
  input wire logic [bdps_pkg::STRAP_W-1:0] analog_strap_input_one,
  input wire logic aux_supply_present,
  input wire logic rail_from_vbus,
  input wire logic fetch_done,
  input wire logic fetch_fail,
  input wire logic typec_connected,
  input wire logic attach_event,
  input wire logic i2c_activity,
  input wire logic pd_msg_rx,
  input wire logic idle_req,
  input wire logic sleep_req,
  output logic fetch_req,
  output logic fetch_spi_en,
  output logic fetch_i2c_en,
  output logic boot_done,
  output logic [1:0] port_role,
  output logic external_sink_gate,
  output logic high_voltage_path_one,
  output logic [4:0] sink_v_max,
  output logic [11:0] sink_min_ma,
  output logic [11:0] sink_max_ma,
  output logic [11:0] source_ma,
  output logic alt_modes_en,
  output logic [1:0] pwr_state,
  output logic [1:0] core_clk_sel,
  output logic osc_24m_en,
  output logic osc_100k_en,
  output logic pd_en,
  output logic spi_en,
  output logic i2c_en,
  output logic pd_msg_drop,
  output logic wake_serve
);

  typedef enum logic [1:0]
  {
    BDPS_B_STRAP,
    BDPS_B_WAIT_AUX,
    BDPS_B_FETCH,
    BDPS_B_RUN
  } bdps_boot_t;
  typedef enum logic [1:0]
  {
    BDPS_ACTIVE,
    BDPS_IDLE,
    BDPS_SLEEP
  } bdps_pwr_t;
  typedef struct packed
  {
    bdps_boot_t boot;
    bdps_pwr_t pwr;
    bdps_pkg::bdps_db_t db;
    bdps_pkg::bdps_cfg_t cfg;
    logic loaded, drop_pend, wake_pend;
    logic [3:0] settle;
    logic [1:0] role;
    logic ext_gate, path_one;
    logic [4:0] vmax;
    logic [11:0] smin, smax, src;
    logic alt, pd_drop, serve;
  } bdps_state_t;
  bdps_state_t st_r, st_nxt;
  bdps_pkg::bdps_db_t dec_db;
  bdps_pkg::bdps_cfg_t dec_cfg;
  logic ext_mode, int_mode, wake_ev;
  bdps_strap_decode u_dec
  (
    .spi_data_in_strap(spi_data_in_strap),
    .analog_strap_input_one(analog_strap_input_one),
    .db_mode(dec_db),
    .cfg(dec_cfg)
  );
  // Mode groups and the wake sources that each low-power state honours.
  assign ext_mode = (st_r.db == bdps_pkg::BDPS_DB_WAIT_SUPPLY_EXT) ||
                    (st_r.db == bdps_pkg::BDPS_DB_HOST_WAIT_EXT);
  assign int_mode = (st_r.db == bdps_pkg::BDPS_DB_WAIT_SUPPLY_INT) ||
                    (st_r.db == bdps_pkg::BDPS_DB_HOST_WAIT_INT);
  assign wake_ev = attach_event || i2c_activity ||
                   (pd_msg_rx && (st_r.pwr == BDPS_IDLE));

  // Next-state logic for boot, power state and the applied port profile.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pd_drop = 1'b0;
    st_nxt.serve = 1'b0;
    case (st_r.boot)
      BDPS_B_STRAP:
      begin
        // Straps are caught once here and never again until reset.
        st_nxt.db = dec_db;
        st_nxt.cfg = dec_cfg;
        st_nxt.boot = BDPS_B_WAIT_AUX;
      end
      BDPS_B_WAIT_AUX:
      begin
        // Wait-for-supply and no-response modes hold startup until the aux supply appears.
        if (aux_supply_present || (st_r.db == bdps_pkg::BDPS_DB_NO_WAIT) ||
            (st_r.db == bdps_pkg::BDPS_DB_HOST_WAIT_EXT) ||
            (st_r.db == bdps_pkg::BDPS_DB_HOST_WAIT_INT))
          st_nxt.boot = BDPS_B_FETCH;
      end
      BDPS_B_FETCH:
      begin
        if (fetch_done)
        begin
          st_nxt.loaded = 1'b1;
          st_nxt.boot = BDPS_B_RUN;
        end
        else if (fetch_fail && (st_r.cfg != bdps_pkg::BDPS_CFG_WAIT))
          st_nxt.boot = BDPS_B_RUN;
      end
      BDPS_B_RUN: st_nxt.boot = BDPS_B_RUN;
      default: st_nxt.boot = BDPS_B_STRAP;
    endcase
    // Default profile from the latched configuration; loaded bundles leave it to firmware.
    st_nxt.role = bdps_pkg::ROLE_OFF;
    st_nxt.vmax = 5'h00;
    st_nxt.smin = 12'h000;
    st_nxt.smax = 12'h000;
    st_nxt.src = 12'h000;
    st_nxt.alt = 1'b0;
    st_nxt.ext_gate = ext_mode;
    st_nxt.path_one = int_mode;
    if ((st_r.boot == BDPS_B_RUN) && !st_r.loaded)
    begin
      case (st_r.cfg)
        bdps_pkg::BDPS_CFG_1:
        begin
          st_nxt.role = bdps_pkg::ROLE_DFP;
          st_nxt.src = bdps_pkg::SRC_MA;
          st_nxt.path_one = 1'b1;
        end
        bdps_pkg::BDPS_CFG_2, bdps_pkg::BDPS_CFG_3:
        begin
          st_nxt.role = bdps_pkg::ROLE_UFP;
          st_nxt.path_one = 1'b1;
          st_nxt.smin = bdps_pkg::SINK_MIN_MA;
          st_nxt.smax = bdps_pkg::SINK_MAX_MA;
          st_nxt.vmax = (st_r.cfg == bdps_pkg::BDPS_CFG_3) ? bdps_pkg::SINK_V_20 :
                        bdps_pkg::SINK_V_5;
        end
        bdps_pkg::BDPS_CFG_4, bdps_pkg::BDPS_CFG_5:
        begin
          st_nxt.role = bdps_pkg::ROLE_UFP;
          st_nxt.ext_gate = 1'b1;
          st_nxt.path_one = 1'b0;
          st_nxt.smin = bdps_pkg::SINK_MIN_MA;
          st_nxt.smax = bdps_pkg::SINK_MAX_MA;
          st_nxt.src = bdps_pkg::SRC_MA;
          st_nxt.vmax = (st_r.cfg == bdps_pkg::BDPS_CFG_5) ? bdps_pkg::SINK_V_20 :
                        bdps_pkg::SINK_V_5;
        end
        default:
        begin
          // Safe and reserved: ports off, plain sink when living on VBUS.
          st_nxt.role = rail_from_vbus ? bdps_pkg::ROLE_LEGACY_SINK : bdps_pkg::ROLE_OFF;
        end
      endcase
    end
    // A VBUS-derived rail never allows sourcing.
    if (rail_from_vbus)
    begin
      st_nxt.src = 12'h000;
      if (st_nxt.role == bdps_pkg::ROLE_DFP)
        st_nxt.role = bdps_pkg::ROLE_LEGACY_SINK;
    end
    // The woken event is served only after clocks have settled.
    // A wake in this same cycle is taken below, so its set wins over this clear.
    if (st_r.settle != 4'h0)
      st_nxt.settle = st_r.settle - 4'h1;
    else if (st_r.wake_pend)
    begin
      st_nxt.wake_pend = 1'b0;
      st_nxt.serve = 1'b1;
      st_nxt.pd_drop = st_r.drop_pend;
      st_nxt.drop_pend = 1'b0;
    end
    // Power states only move once boot is over.
    if (st_r.boot == BDPS_B_RUN)
    begin
      case (st_r.pwr)
        BDPS_ACTIVE:
        begin
          if (sleep_req && !typec_connected)
            st_nxt.pwr = BDPS_SLEEP;
          else if (idle_req || sleep_req)
            st_nxt.pwr = BDPS_IDLE;
        end
        BDPS_IDLE, BDPS_SLEEP:
        begin
          if (wake_ev)
          begin
            st_nxt.pwr = BDPS_ACTIVE;
            st_nxt.settle = bdps_pkg::WAKE_SETTLE_CYC;
            st_nxt.wake_pend = 1'b1;
            st_nxt.drop_pend = pd_msg_rx && (st_r.pwr == BDPS_IDLE);
          end
          else if ((st_r.pwr == BDPS_SLEEP) && typec_connected)
            st_nxt.pwr = BDPS_IDLE;
        end
        default: st_nxt.pwr = BDPS_ACTIVE;
      endcase
    end
  end
  // One register for all state.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.boot <= BDPS_B_STRAP;
      st_r.pwr <= BDPS_ACTIVE;
    end
    else
      st_r <= st_nxt;
  end

  // Clock, 24 MHz oscillator and feature enables track the power state; the 100 kHz oscillator always runs.
  assign core_clk_sel = (st_r.pwr == BDPS_SLEEP) ? bdps_pkg::CLK_SEL_100K :
                        (st_r.pwr == BDPS_IDLE) ? bdps_pkg::CLK_SEL_5M : bdps_pkg::CLK_SEL_12M;
  assign osc_24m_en = (st_r.pwr != BDPS_SLEEP);
  assign osc_100k_en = 1'b1;
  assign pd_en = (st_r.pwr == BDPS_ACTIVE) && (st_r.settle == 4'h0);
  assign spi_en = pd_en;
  assign i2c_en = (st_r.pwr != BDPS_SLEEP);
  assign fetch_req = (st_r.boot == BDPS_B_FETCH);
  assign fetch_spi_en = fetch_req;
  assign fetch_i2c_en = fetch_req;
  assign boot_done = (st_r.boot == BDPS_B_RUN);
  assign pwr_state = st_r.pwr;
  assign port_role = st_r.role;
  assign external_sink_gate = st_r.ext_gate;
  assign high_voltage_path_one = st_r.path_one;
  assign sink_v_max = st_r.vmax;
  assign sink_min_ma = st_r.smin;
  assign sink_max_ma = st_r.smax;
  assign source_ma = st_r.src;
  assign alt_modes_en = st_r.alt;
  assign pd_msg_drop = st_r.pd_drop;
  assign wake_serve = st_r.serve;
  sleep_conn_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.pwr == BDPS_SLEEP) |-> $past(!typec_connected) || $past(st_r.pwr == BDPS_SLEEP))
    else $error("Sleep entered while connected.");
  osc_off_a: assert property (@(posedge clk) disable iff (reset)
    osc_24m_en == (core_clk_sel != bdps_pkg::CLK_SEL_100K))
    else $error("Oscillator enable disagrees with clock select.");
  wait_hold_a: assert property (@(posedge clk) disable iff (reset)
    (fetch_req && fetch_fail && !fetch_done && st_r.cfg == bdps_pkg::BDPS_CFG_WAIT)
    |=> fetch_req)
    else $error("Infinite wait left boot.");
  strap_hold_a: assert property (@(posedge clk) disable iff (reset)
    (st_r.boot != BDPS_B_STRAP) |=> $stable(st_r.cfg) && $stable(st_r.db))
    else $error("Strap result changed after boot.");
  vbus_sink_a: assert property (@(posedge clk) disable iff (reset)
    rail_from_vbus |=> (source_ma == 12'h000))
    else $error("Sourcing while rail is from VBUS.");
  sequence wake_seq;
    (st_r.pwr != BDPS_ACTIVE) && wake_ev && boot_done;
  endsequence
  wake_serve_a: assert property (@(posedge clk) disable iff (reset)
    wake_seq |=> !wake_serve [*4] ##1 !wake_serve ##1 (wake_serve && pd_en))
    else $error("Wake event not served after clocks settle.");
  pd_drop_a: assert property (@(posedge clk) disable iff (reset)
    pd_msg_drop |-> wake_serve)
    else $error("Dropped message without a wake.");
  fetch_spi_a: assert property (@(posedge clk) disable iff (reset)
    fetch_req |-> fetch_spi_en && fetch_i2c_en && !boot_done)
    else $error("Fetch not offered on both interfaces.");

endmodule
`default_nettype wire

// ==== bdps_host_model.sv ====
// Behavioural host controller and configuration flash on the far side of the boot fetch.
`timescale 1ns/1ps
`default_nettype none
module bdps_host_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_req,
  input wire logic fetch_spi_en,
  input wire logic fetch_i2c_en,
  input wire logic [1:0] mode,
  input wire logic [3:0] dly,
  output logic fetch_done,
  output logic fetch_fail
);
  int cnt = 0;

  // Each attempt is answered dly+1 cycles after it starts: mode 0 fails, 1 loads a bundle, 2 stays silent.
  // The answer repeats while the request stands, so an endless wait sees failure after failure.
  // Answers move by non-blocking assignment on the edge, so no input race with the bench.
  always @(posedge clk)
  begin
    if (reset || !(fetch_req && (fetch_spi_en || fetch_i2c_en)))
    begin
      cnt <= 0;
      fetch_done <= 1'b0;
      fetch_fail <= 1'b0;
    end
    else if (cnt >= int'(dly))
    begin
      cnt <= 0;
      fetch_done <= (mode == 2'h1);
      fetch_fail <= (mode == 2'h0);
    end
    else
    begin
      cnt <= cnt + 1;
      fetch_done <= 1'b0;
      fetch_fail <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== bdps_bench.sv ====
// Self-checking bench for the boot default and power state block.
`timescale 1ns/1ps
`default_nettype none
module bdps_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b1;
  logic [3:0] band = 4'h0;
  logic aux = 1'b1;
  logic rail = 1'b0;
  logic conn = 1'b0;
  logic attach = 1'b0;
  logic i2c_act = 1'b0;
  logic pd_rx = 1'b0;
  logic idle_req = 1'b0;
  logic sleep_req = 1'b0;
  logic [1:0] host_mode = 2'h0;
  logic [3:0] host_dly = 4'h1;
  logic fetch_done, fetch_fail, fetch_req, fetch_spi_en, fetch_i2c_en, boot_done;
  logic ext_gate, hv1, alt, osc24, osc100k, pd_en, spi_en, i2c_en, drop, serve;
  logic [1:0] role, pwr, clk_sel;
  logic [4:0] sink_v;
  logic [11:0] sink_min, sink_max, src;
  int err_total = 0;
  int num_checks = 0;
  wire logic [43:0] prof = {role, sink_v, sink_min, sink_max, src, alt};
  wire logic [8:0] pw = {pwr, clk_sel, osc24, osc100k, pd_en, spi_en, i2c_en};

  always #5 clk = ~clk;

  bdps_top u_dut (.clk(clk), .reset(reset), .spi_data_in_strap(strap),
    .analog_strap_input_one(band), .aux_supply_present(aux), .rail_from_vbus(rail),
    .fetch_done(fetch_done), .fetch_fail(fetch_fail), .typec_connected(conn),
    .attach_event(attach), .i2c_activity(i2c_act), .pd_msg_rx(pd_rx), .idle_req(idle_req),
    .sleep_req(sleep_req), .fetch_req(fetch_req), .fetch_spi_en(fetch_spi_en),
    .fetch_i2c_en(fetch_i2c_en), .boot_done(boot_done), .port_role(role),
    .external_sink_gate(ext_gate), .high_voltage_path_one(hv1), .sink_v_max(sink_v),
    .sink_min_ma(sink_min), .sink_max_ma(sink_max), .source_ma(src), .alt_modes_en(alt),
    .pwr_state(pwr), .core_clk_sel(clk_sel), .osc_24m_en(osc24), .osc_100k_en(osc100k),
    .pd_en(pd_en), .spi_en(spi_en), .i2c_en(i2c_en), .pd_msg_drop(drop), .wake_serve(serve));

  bdps_host_model u_host (.clk(clk), .reset(reset), .fetch_req(fetch_req),
    .fetch_spi_en(fetch_spi_en), .fetch_i2c_en(fetch_i2c_en), .mode(host_mode),
    .dly(host_dly), .fetch_done(fetch_done), .fetch_fail(fetch_fail));

  task final_report();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Every input moves 1 ns after a rising edge, where the design's outputs have settled.
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input logic [43:0] got, input logic [43:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [43:0] p(logic [1:0] r, logic [4:0] v, logic [11:0] mn,
    logic [11:0] mx, logic [11:0] s);
    return {r, v, mn, mx, s, 1'b0};
  endfunction

  task rst(input logic s, input logic [3:0] b, input logic r);
    strap = s;
    band = b;
    rail = r;
    reset = 1'b1;
    tick(16);
    reset = 1'b0;
  endtask

  // Boot with the far side failing the fetch, so the strap default is applied.
  task boot(input logic s, input logic [3:0] b, input logic r);
    int n;
    rst(s, b, r);
    n = 0;
    while (boot_done !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    chk(44'(boot_done), 44'h1);
    tick(2);
  endtask

  task req(input logic slp);
    idle_req = !slp;
    sleep_req = slp;
    tick(1);
    idle_req = 1'b0;
    sleep_req = 1'b0;
    tick(3);
  endtask

  // Wake kinds: 0 host bus activity, 1 attach, 2 PD message.
  task wake(input int k, input logic drop_exp);
    int n;
    i2c_act = (k == 0);
    attach = (k == 1);
    pd_rx = (k == 2);
    tick(1);
    {i2c_act, attach, pd_rx} = 3'h0;
    tick(1);
    chk(44'({pwr, serve}), 44'h0);
    n = 0;
    while (serve !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    chk(44'(n), 44'(bdps_pkg::WAKE_SETTLE_CYC));
    chk(44'({serve, drop, pd_en, osc24, clk_sel}), 44'({3'h7, 1'b1, 2'h0} ^ {1'b0, !drop_exp, 4'h0}));
  endtask

  initial
  begin
    #400000;
    err_total++;
    $display("Error at %0t: watchdog expired before the tests ended", $time);
    final_report();
  end

  initial
  begin
    boot(1'b1, 4'h0, 1'b0);
    chk(prof, p(bdps_pkg::ROLE_OFF, 5'h0, 12'h0, 12'h0, 12'h0));
    boot(1'b1, 4'h0, 1'b1);
    chk(prof, p(bdps_pkg::ROLE_LEGACY_SINK, 5'h0, 12'h0, 12'h0, 12'h0));
    boot(1'b0, 4'h1, 1'b0);
    chk(prof, p(bdps_pkg::ROLE_DFP, 5'h0, 12'h0, 12'h0, 12'hbb8));
    boot(1'b0, 4'h4, 1'b0);
    chk(prof, p(bdps_pkg::ROLE_UFP, 5'h14, 12'h384, 12'hbb8, 12'h0));
    boot(1'b0, 4'h6, 1'b0);
    chk(prof, p(bdps_pkg::ROLE_UFP, 5'h05, 12'h384, 12'hbb8, 12'hbb8));
    boot(1'b0, 4'h9, 1'b0);
    chk(prof, p(bdps_pkg::ROLE_UFP, 5'h14, 12'h384, 12'hbb8, 12'hbb8));
    boot(1'b0, 4'h7, 1'b0);
    chk(prof, p(bdps_pkg::ROLE_OFF, 5'h0, 12'h0, 12'h0, 12'h0));
    boot(1'b0, 4'h1, 1'b1);
    chk(44'(role == bdps_pkg::ROLE_DFP), 44'h0);
    boot(1'b1, 4'h2, 1'b0);
    chk(44'({ext_gate, hv1}), 44'h1);
    boot(1'b1, 4'h4, 1'b0);
    chk(44'({ext_gate, hv1}), 44'h2);
    // A wait-for-supply mode must hold off the fetch until the auxiliary supply appears.
    aux = 1'b0;
    rst(1'b1, 4'h2, 1'b0);
    tick(10);
    chk(44'(fetch_req), 44'h0);
    aux = 1'b1;
    tick(1);
    chk(44'({fetch_req, fetch_spi_en | fetch_i2c_en}), 44'h3);
    // Host-wait and no-wait modes fetch without the auxiliary supply; no-response does not.
    aux = 1'b0;
    rst(1'b1, 4'h5, 1'b0);
    tick(3);
    chk(44'({fetch_req, ext_gate, hv1}), 44'h6);
    rst(1'b1, 4'h6, 1'b0);
    tick(3);
    chk(44'(fetch_req), 44'h1);
    rst(1'b1, 4'h0, 1'b0);
    tick(10);
    chk(44'(fetch_req), 44'h0);
    aux = 1'b1;
    // Endless wait ignores slow repeated failures, then a loaded bundle ends boot.
    host_dly = 4'h8;
    rst(1'b1, 4'h3, 1'b0);
    tick(40);
    chk(44'({fetch_req, boot_done}), 44'h2);
    host_mode = 2'h1;
    tick(20);
    chk(44'(boot_done), 44'h1);
    host_mode = 2'h0;
    host_dly = 4'h1;
    boot(1'b0, 4'h2, 1'b0);
    strap = 1'b1;
    band = 4'h0;
    tick(5);
    chk(prof, p(bdps_pkg::ROLE_UFP, 5'h05, 12'h384, 12'hbb8, 12'h0));
    chk(44'(pw), 44'({2'h0, bdps_pkg::CLK_SEL_12M, 5'h1f}));
    req(1'b0);
    chk(44'(pw), 44'({2'h1, bdps_pkg::CLK_SEL_5M, 5'h19}));
    wake(0, 1'b0);
    req(1'b0);
    wake(2, 1'b1);
    conn = 1'b1;
    req(1'b1);
    chk(44'(pwr), 44'h1);
    wake(1, 1'b0);
    conn = 1'b0;
    req(1'b1);
    chk(44'(pw), 44'({2'h2, bdps_pkg::CLK_SEL_100K, 5'h08}));
    pd_rx = 1'b1;
    tick(1);
    pd_rx = 1'b0;
    tick(8);
    chk(44'({pwr, serve}), 44'h4);
    wake(1, 1'b0);
    req(1'b1);
    wake(0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
